//--- dv/ir_emitter_model.sv
// Infrared emitter model: counts clocks with the light on
`timescale 1ns/1ps

module ir_emitter_model (
	input  wire logic        clk,
	input  wire logic        pin_out,
	input  wire logic        pin_oe,
	output logic      [15:0] lit_cycles
);
	logic last;
	logic lit;

	// Released pin floats: show a changing level, never a stale one
	assign lit = pin_oe ? pin_out : ~last;

	initial lit_cycles = 16'h0000;
	initial last = 1'b0;

	always @(posedge clk) begin
		last <= lit;
		lit_cycles <= lit_cycles + ((lit === 1'b1) ? 16'h0001 : 16'h0000);
	end
endmodule

//--- dv/tb.sv
// Self-checking bench for the infrared modulator control block
`timescale 1ns/1ps

module tb;
	localparam logic [3:0] OC  = ir_mod_pkg::OFF_IR_OUTPUT_CONTROL;
	localparam logic [3:0] MSC = ir_mod_pkg::OFF_MOD_STATUS_CONTROL;
	localparam logic [3:0] MPL = ir_mod_pkg::OFF_MARK_PERIOD_LOW;
	localparam logic [3:0] SPL = ir_mod_pkg::OFF_SPACE_PERIOD_LOW;
	localparam logic [3:0] IST = ir_mod_pkg::OFF_IRQ_STATUS;
	localparam logic [3:0] IMK = ir_mod_pkg::OFF_IRQ_MASK;

	logic        clk;
	logic        nrst;
	logic [3:0]  addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic [7:0]  rdata;
	logic        irq;
	logic        pin_out;
	logic        pin_oe;
	logic [15:0] lit;
	int          cyc;
	int          bad_count;
	int          n_tests;
	int          t0;
	int          h0;

	ir_carrier_modulator_control u_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .irq(irq), .ir_pin_out(pin_out), .ir_pin_oe(pin_oe));
	ir_emitter_model u_led (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .lit_cycles(lit));

	always #50 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic cmp8(input string w, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", w, e, g);
		end
	endtask

	task automatic cmp_n(input string w, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %0d seen %0d", w, e, g);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_cmp(input string w, input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 cmp8(w, e, rdata);
	endtask

	task automatic pin_cmp(input string w, input logic [1:0] e);
		repeat (2) @(posedge clk);
		#1 cmp8(w, {6'h00, e}, {6'h00, pin_oe, pin_out & pin_oe});
	endtask

	task automatic irq_cmp(input string w, input logic e);
		@(posedge clk);
		#1 cmp8(w, {7'h00, e}, {7'h00, irq});
	endtask

	task automatic wait_irq();
		for (int i = 0; i < 2000; i++) begin
			@(posedge clk);
			#1;
			if (irq === 1'b1)
				break;
		end
	endtask

	// First interval after a start or reload is skipped: in extended space the first cycle still has its mark
	task automatic meas(input int p, input int h);
		wait_irq();
		wr_reg(IST, 8'h01);
		wait_irq();
		t0 = cyc;
		h0 = lit;
		wr_reg(IST, 8'h01);
		wait_irq();
		cmp_n("cycle length", p, cyc - t0);
		cmp_n("light length", h, lit - h0);
		wr_reg(IST, 8'h01);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		$display("watchdog expired");
		final_report();
	end

	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		cyc = 0;
		bad_count = 0;
		n_tests = 0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		rd_cmp("output control", OC, 8'h00);
		rd_cmp("status control", MSC, 8'h00);
		pin_cmp("pin", 2'b00);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			wr_reg(OC, {i[2:0], 5'h00});
			rd_cmp("output control", OC, {i[2:0], 5'h00});
			pin_cmp("pin", {i[0], i[0] & ~(i[2] ^ i[1])});
		end
		$display("test latch done");
		wr_reg(OC, 8'h60);
		wr_reg(MPL, 8'h40);
		wr_reg(SPL, 8'h40);
		wr_reg(MSC, 8'h0b);
		rd_cmp("mark low", MPL, 8'h40);
		rd_cmp("status control", MSC, 8'h8b);
		irq_cmp("irq", 1'b1);
		rd_cmp("space low", SPL, 8'h40);
		rd_cmp("status control", MSC, 8'h0b);
		irq_cmp("irq", 1'b0);
		wr_reg(MSC, 8'h0a);
		wr_reg(MSC, 8'h0b);
		rd_cmp("status control", MSC, 8'h0b);
		wait_irq();
		rd_cmp("status control", MSC, 8'h8b);
		wr_reg(MSC, 8'h08);
		repeat (300) @(posedge clk);
		$display("test flag done");
		rd_cmp("irq status", IST, 8'h01);
		wr_reg(IMK, 8'h01);
		irq_cmp("irq", 1'b1);
		wr_reg(IST, 8'h01);
		rd_cmp("irq status", IST, 8'h00);
		wr_reg(4'hc, 8'hff);
		rd_cmp("unmapped", 4'hc, 8'h00);
		$display("test interrupt done");
		wr_reg(MPL, 8'h02);
		wr_reg(SPL, 8'h03);
		for (int d = 0; d < 4; d++) begin
			wr_reg(MSC, {1'b0, d[1:0], 5'h09});
			meas(7 << d, 3 << d);
			wr_reg(MSC, 8'h08);
			repeat (100) @(posedge clk);
		end
		// Space-only cycle is two ticks; divide by 2 keeps it above the clear overhead
		wr_reg(MSC, 8'h39);
		meas(4, 0);
		wr_reg(MSC, 8'h08);
		repeat (100) @(posedge clk);
		wr_reg(MSC, 8'h09);
		meas(7, 3);
		wr_reg(MPL, 8'h05);
		meas(10, 6);
		wr_reg(MSC, 8'h08);
		repeat (100) @(posedge clk);
		pin_cmp("pin", 2'b10);
		$display("test timing done");
		for (int k = 0; k < 4; k++)
			wr_reg(k[3:0], 8'h01);
		wr_reg(MPL, 8'h03);
		wr_reg(SPL, 8'h03);
		wr_reg(MSC, 8'h05);
		meas(8, 2);
		wr_reg(MSC, 8'h00);
		repeat (100) @(posedge clk);
		$display("test carrier done");
		wr_reg(MSC, 8'h74);
		rd_cmp("status control", MSC, 8'hf4);
		$display("test fields done");
		final_report();
	end
endmodule

//--- hdl/ir_carrier_modulator_control.sv
// Infrared carrier modulator: control registers, prescaler, carrier, modulator and pin
//
// Summary of operation
// RULE1: Latch bit reads back; drives pin when idle
// RULE2: Polarity bit zero inverts the pin
// RULE3: Enabled pin drives modulator or latch value
// RULE4: Disabled pin floats; reset disables the pin
// RULE5: Enabling idle modulator sets end-of-cycle flag
// RULE6: Flag set when counter matches space period
// RULE7: Cycle end reloads counter and space period
// RULE8: Flag clears after status read, period access
// RULE9: Re-enable inside running cycle sets no flag
// RULE10: Prescaler divides bus clock by 1,2,4,8
// RULE11: Software keeps prescaler steady while transmitting
// RULE12: Extended space bit enables extended space
// RULE13: Baseband holds carrier high, generator stopped
// RULE14: Without baseband carrier toggles at programmed rate
// RULE15: Baseband cleared by reset; software avoids mid-transmission writes
// RULE16: FSK bit picks time/baseband or FSK
// RULE17: Interrupt while flag and its enable set
// RULE18: Enable starts; disable finishes cycle, output low
// RULE19: Mark follows carrier, space holds output low
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps

module ir_carrier_modulator_control (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	output logic            irq,
	output logic            ir_pin_out,
	output logic            ir_pin_oe
);

	ir_mod_pkg::state_t s_r;
	ir_mod_pkg::state_t s_nxt;

	logic        tick;
	logic        start;
	logic        cyc_end;
	logic        mod_out;
	logic        eoc_set;
	logic        eoc_clr;
	logic [7:0]  car_period;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [2:0] presc_limit(input logic [1:0] div);
		presc_limit = 3'((4'h1 << div) - 4'h1);
	endfunction

	function automatic logic is_period_low(input logic [3:0] a);
		is_period_low = (a == ir_mod_pkg::OFF_MARK_PERIOD_LOW) || (a == ir_mod_pkg::OFF_SPACE_PERIOD_LOW);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_nxt = s_r;

		// Module clock from the bus clock
		tick = s_r.active && (s_r.pre_cnt == presc_limit(s_r.div)); // RULE10
		// No start while a cycle still runs, so a quick re-enable raises no flag
		start = s_r.modulator_enable && !s_r.modulator_enable_d && !s_r.active; // RULE5 RULE9
		cyc_end = tick && !s_r.mark && (s_r.mod_cnt == s_r.space_r); // RULE6
		mod_out = s_r.active && s_r.mark && s_r.car_out; // RULE19 RULE18
		// The closing cycle after a disable ends silently
		eoc_set = start || (cyc_end && s_r.modulator_enable); // RULE6 RULE9
		eoc_clr = s_r.clear_armed && (rd || wr) && is_period_low(addr); // RULE8
		// Secondary pair only on alternate FSK cycles
		car_period = s_r.car_sec ? s_r.carrier_data[s_r.car_out ? 2 : 3]
			: s_r.carrier_data[s_r.car_out ? 0 : 1];

		s_nxt.modulator_enable_d = s_r.modulator_enable;

		// Prescaler; stopped clocks save power while idle
		if (!s_r.active || tick) begin
			s_nxt.pre_cnt = 3'h0;
		end else begin
			s_nxt.pre_cnt = s_r.pre_cnt + 3'h1;
		end

		// Carrier generator
		if (s_r.unmodulated_mode_enable) begin
			s_nxt.car_out = 1'b1; // RULE13
			s_nxt.car_cnt = 8'h00;
		end else if (tick) begin
			// Pair switch can leave the count past the new period
			if (s_r.car_cnt >= car_period - 8'h01) begin
				s_nxt.car_out = !s_r.car_out; // RULE14
				s_nxt.car_cnt = 8'h00;
			end else begin
				s_nxt.car_cnt = s_r.car_cnt + 8'h01;
			end
		end

		// Modulator
		if (start) begin
			s_nxt.active = 1'b1; // RULE18
			s_nxt.mark = 1'b1;
			s_nxt.car_out = 1'b1;
			s_nxt.car_cnt = 8'h00;
			s_nxt.car_sec = 1'b0;
			s_nxt.mod_cnt = {s_r.period_data[0], s_r.period_data[1]};
			s_nxt.space_r = {s_r.period_data[2], s_r.period_data[3]};
		end else if (cyc_end) begin
			s_nxt.mod_cnt = {s_r.period_data[0], s_r.period_data[1]}; // RULE7
			s_nxt.space_r = {s_r.period_data[2], s_r.period_data[3]}; // RULE7
			s_nxt.mark = !s_r.extended_space_enable; // RULE12
			s_nxt.car_sec = s_r.fsk && !s_r.car_sec; // RULE16
			s_nxt.active = s_r.modulator_enable; // RULE18
		end else if (tick) begin
			if (s_r.mark) begin
				if (s_r.mod_cnt == 16'h0000) begin
					s_nxt.mark = 1'b0;
				end else begin
					s_nxt.mod_cnt = s_r.mod_cnt - 16'h0001;
				end
			end else begin
				s_nxt.mod_cnt = s_r.mod_cnt + 16'h0001;
			end
		end

		// Flag: a set in the clearing cycle wins
		if (eoc_set) begin
			s_nxt.end_of_cycle_flag = 1'b1; // RULE5 RULE6
		end else if (eoc_clr) begin
			s_nxt.end_of_cycle_flag = 1'b0; // RULE8
		end
		if (rd && addr == ir_mod_pkg::OFF_MOD_STATUS_CONTROL) begin
			s_nxt.clear_armed = 1'b1;
		end else if (eoc_clr) begin
			s_nxt.clear_armed = 1'b0;
		end

		// Sticky interrupt status, write one to clear
		if (eoc_set) begin
			s_nxt.irq_sts = 1'b1;
		end else if (wr && addr == ir_mod_pkg::OFF_IRQ_STATUS && wdata[ir_mod_pkg::IRQ_EOC]) begin
			s_nxt.irq_sts = 1'b0;
		end

		// Register writes
		if (wr) begin
			unique case (addr)
				ir_mod_pkg::OFF_CARRIER_PRI_HIGH,
				ir_mod_pkg::OFF_CARRIER_PRI_LOW,
				ir_mod_pkg::OFF_CARRIER_SEC_HIGH,
				ir_mod_pkg::OFF_CARRIER_SEC_LOW: begin
					s_nxt.carrier_data[addr[1:0]] = wdata;
				end
				ir_mod_pkg::OFF_IR_OUTPUT_CONTROL: begin
					s_nxt.oc_latch = wdata[ir_mod_pkg::OC_LATCH]; // RULE1
					s_nxt.oc_pol = wdata[ir_mod_pkg::OC_POL];
					s_nxt.oc_pen = wdata[ir_mod_pkg::OC_PEN];
				end
				ir_mod_pkg::OFF_MOD_STATUS_CONTROL: begin
					// Divider and baseband are live, not double buffered
					s_nxt.div = wdata[ir_mod_pkg::MSC_DIV_H:ir_mod_pkg::MSC_DIV_L]; // RULE11
					s_nxt.extended_space_enable = wdata[ir_mod_pkg::MSC_EXTENDED_SPACE_ENABLE];
					s_nxt.unmodulated_mode_enable = wdata[ir_mod_pkg::MSC_UNMODULATED_MODE_ENABLE]; // RULE15
					s_nxt.fsk = wdata[ir_mod_pkg::MSC_FSK];
					s_nxt.end_of_cycle_irq_enable = wdata[ir_mod_pkg::MSC_END_OF_CYCLE_IRQ_ENABLE];
					s_nxt.modulator_enable = wdata[ir_mod_pkg::MSC_MODULATOR_ENABLE];
				end
				ir_mod_pkg::OFF_MARK_PERIOD_HIGH,
				ir_mod_pkg::OFF_MARK_PERIOD_LOW,
				ir_mod_pkg::OFF_SPACE_PERIOD_HIGH,
				ir_mod_pkg::OFF_SPACE_PERIOD_LOW: begin
					s_nxt.period_data[2'(addr - ir_mod_pkg::OFF_MARK_PERIOD_HIGH)] = wdata;
				end
				ir_mod_pkg::OFF_IRQ_MASK: begin
					s_nxt.irq_msk = wdata[ir_mod_pkg::IRQ_EOC];
				end
				default: begin
				end
			endcase
		end

		// Register reads, data in the next cycle only
		s_nxt.rdata = 8'h00;
		if (rd) begin
			unique case (addr)
				ir_mod_pkg::OFF_CARRIER_PRI_HIGH,
				ir_mod_pkg::OFF_CARRIER_PRI_LOW,
				ir_mod_pkg::OFF_CARRIER_SEC_HIGH,
				ir_mod_pkg::OFF_CARRIER_SEC_LOW: begin
					s_nxt.rdata = s_r.carrier_data[addr[1:0]];
				end
				ir_mod_pkg::OFF_IR_OUTPUT_CONTROL: begin
					s_nxt.rdata[ir_mod_pkg::OC_LATCH] = s_r.oc_latch; // RULE1
					s_nxt.rdata[ir_mod_pkg::OC_POL] = s_r.oc_pol;
					s_nxt.rdata[ir_mod_pkg::OC_PEN] = s_r.oc_pen;
				end
				ir_mod_pkg::OFF_MOD_STATUS_CONTROL: begin
					s_nxt.rdata[ir_mod_pkg::MSC_END_OF_CYCLE_FLAG] = s_r.end_of_cycle_flag;
					s_nxt.rdata[ir_mod_pkg::MSC_DIV_H:ir_mod_pkg::MSC_DIV_L] = s_r.div;
					s_nxt.rdata[ir_mod_pkg::MSC_EXTENDED_SPACE_ENABLE] = s_r.extended_space_enable;
					s_nxt.rdata[ir_mod_pkg::MSC_UNMODULATED_MODE_ENABLE] = s_r.unmodulated_mode_enable;
					s_nxt.rdata[ir_mod_pkg::MSC_FSK] = s_r.fsk;
					s_nxt.rdata[ir_mod_pkg::MSC_END_OF_CYCLE_IRQ_ENABLE] = s_r.end_of_cycle_irq_enable;
					s_nxt.rdata[ir_mod_pkg::MSC_MODULATOR_ENABLE] = s_r.modulator_enable;
				end
				ir_mod_pkg::OFF_MARK_PERIOD_HIGH,
				ir_mod_pkg::OFF_MARK_PERIOD_LOW,
				ir_mod_pkg::OFF_SPACE_PERIOD_HIGH,
				ir_mod_pkg::OFF_SPACE_PERIOD_LOW: begin
					s_nxt.rdata = s_r.period_data[2'(addr - ir_mod_pkg::OFF_MARK_PERIOD_HIGH)];
				end
				ir_mod_pkg::OFF_IRQ_STATUS: begin
					s_nxt.rdata[ir_mod_pkg::IRQ_EOC] = s_r.irq_sts;
				end
				ir_mod_pkg::OFF_IRQ_MASK: begin
					s_nxt.rdata[ir_mod_pkg::IRQ_EOC] = s_r.irq_msk;
				end
				default: begin
				end
			endcase
		end

		// Pin and interrupt, registered
		s_nxt.pin_oe = s_r.oc_pen; // RULE4
		s_nxt.pin_out = s_r.oc_pol ~^ (s_r.modulator_enable ? mod_out : s_r.oc_latch); // RULE2 RULE3
		s_nxt.irq = (s_r.end_of_cycle_flag && s_r.end_of_cycle_irq_enable) || (s_r.irq_sts && s_r.irq_msk); // RULE17
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_r <= ir_mod_pkg::STATE_RESET; // RULE4 RULE15
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata = s_r.rdata;
	assign irq = s_r.irq;
	assign ir_pin_out = s_r.pin_out;
	assign ir_pin_oe = s_r.pin_oe;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	chk_latch_drive: assert property (!s_r.modulator_enable && s_r.oc_pen |=> ir_pin_out == ($past(s_r.oc_pol) ~^ $past(s_r.oc_latch))) // RULE1
		else $error("pin does not follow latch and polarity");
	chk_pin_float: assert property (!s_r.oc_pen |=> !ir_pin_oe) // RULE4
		else $error("pin driven while disabled");
	chk_start_flag: assert property (start |=> s_r.end_of_cycle_flag && s_r.active ##1 (s_r.end_of_cycle_flag || $past(eoc_clr))) // RULE5
		else $error("flag not set at start");
	chk_cycle_reload: assert property (cyc_end |=> s_r.mod_cnt == {$past(s_r.period_data[0]), $past(s_r.period_data[1])}) // RULE7
		else $error("cycle end without counter reload");
	chk_space_reload: assert property (cyc_end |=> s_r.space_r == {$past(s_r.period_data[2]), $past(s_r.period_data[3])}) // RULE7
		else $error("cycle end without space reload");
	chk_cycle_flag: assert property (cyc_end && s_r.modulator_enable |=> s_r.end_of_cycle_flag) // RULE6
		else $error("cycle end without flag");
	chk_flag_clear: assert property (eoc_clr && !eoc_set |=> !s_r.end_of_cycle_flag) // RULE8
		else $error("flag not cleared by access");
	chk_no_reenable: assert property (s_r.modulator_enable && !s_r.modulator_enable_d && s_r.active && !cyc_end && !s_r.end_of_cycle_flag |=> !s_r.end_of_cycle_flag) // RULE9
		else $error("flag set on re-enable");
	chk_unmodulated_mode_enable_carrier: assert property (s_r.unmodulated_mode_enable ##1 s_r.unmodulated_mode_enable |-> s_r.car_out ##1 s_r.car_out) // RULE13
		else $error("carrier not held high in baseband");
	chk_irq_level: assert property (s_r.end_of_cycle_flag && s_r.end_of_cycle_irq_enable |=> irq) // RULE17
		else $error("interrupt missing");
	chk_space_low: assert property (s_r.modulator_enable && (!s_r.active || !s_r.mark) // RULE18 RULE19
		|=> ir_pin_out == !$past(s_r.oc_pol))
		else $error("modulator output high outside mark");
	chk_mark_carrier: assert property (s_r.modulator_enable && s_r.active && s_r.mark // RULE19 RULE2
		|=> ir_pin_out == ($past(s_r.oc_pol) ~^ $past(s_r.car_out)))
		else $error("pin does not follow carrier in mark");
	chk_pin_enable: assert property (s_r.oc_pen |=> ir_pin_oe) // RULE3
		else $error("enabled pin not driven");
	chk_extended_space: assert property (cyc_end && s_r.extended_space_enable |=> !s_r.mark) // RULE12
		else $error("mark phase in extended space");
	chk_fsk_alternate: assert property (cyc_end && s_r.fsk |=> s_r.car_sec != $past(s_r.car_sec)) // RULE16
		else $error("carrier pair does not alternate");
	chk_time_primary: assert property (cyc_end && !s_r.fsk |=> !s_r.car_sec) // RULE16
		else $error("secondary pair used outside fsk");
	chk_prescale_gap: assert property (tick && s_r.div == 2'h3 |=> !tick [*7]) // RULE10
		else $error("prescaler tick too early");
	chk_carrier_toggle: assert property (tick && !s_r.unmodulated_mode_enable && car_period == 8'h01 |=> s_r.car_out != $past(s_r.car_out)) // RULE14
		else $error("carrier does not toggle");

	cov_start: cover property (start ##1 s_r.end_of_cycle_flag);
	cov_cycle_end: cover property (cyc_end ##1 irq);
	cov_flag_clear: cover property (rd && addr == ir_mod_pkg::OFF_MOD_STATUS_CONTROL ##[1:5] eoc_clr);
	cov_stop: cover property (s_r.active && !s_r.modulator_enable ##[1:100] !s_r.active);
	cov_extended: cover property (cyc_end && s_r.extended_space_enable ##1 !s_r.mark);

endmodule

//--- hdl/ir_mod_pkg.sv
// Package: register map, field positions and state layout of the infrared modulator
package ir_mod_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// Register indices (byte addresses on the plain port)
	localparam logic [3:0] OFF_CARRIER_PRI_HIGH   = 4'h0;
	localparam logic [3:0] OFF_CARRIER_PRI_LOW    = 4'h1;
	localparam logic [3:0] OFF_CARRIER_SEC_HIGH   = 4'h2;
	localparam logic [3:0] OFF_CARRIER_SEC_LOW    = 4'h3;
	localparam logic [3:0] OFF_IR_OUTPUT_CONTROL  = 4'h4;
	localparam logic [3:0] OFF_MOD_STATUS_CONTROL = 4'h5;
	localparam logic [3:0] OFF_MARK_PERIOD_HIGH   = 4'h6;
	localparam logic [3:0] OFF_MARK_PERIOD_LOW    = 4'h7;
	localparam logic [3:0] OFF_SPACE_PERIOD_HIGH  = 4'h8;
	localparam logic [3:0] OFF_SPACE_PERIOD_LOW   = 4'h9;
	localparam logic [3:0] OFF_IRQ_STATUS         = 4'ha;
	localparam logic [3:0] OFF_IRQ_MASK           = 4'hb;

	// ir_output_control fields
	localparam int OC_LATCH = 7;
	localparam int OC_POL   = 6;
	localparam int OC_PEN   = 5;

	// modulator_status_control fields
	localparam int MSC_END_OF_CYCLE_FLAG  = 7;
	localparam int MSC_DIV_H = 6;
	localparam int MSC_DIV_L = 5;
	localparam int MSC_EXTENDED_SPACE_ENABLE = 4;
	localparam int MSC_UNMODULATED_MODE_ENABLE  = 3;
	localparam int MSC_FSK   = 2;
	localparam int MSC_END_OF_CYCLE_IRQ_ENABLE = 1;
	localparam int MSC_MODULATOR_ENABLE = 0;

	// Interrupt status and mask field
	localparam int IRQ_EOC = 0;

	typedef struct packed {
		logic [3:0][7:0] carrier_data;
		logic [3:0][7:0] period_data;
		logic            oc_latch;
		logic            oc_pol;
		logic            oc_pen;
		logic            end_of_cycle_flag;
		logic [1:0]      div;
		logic            extended_space_enable;
		logic            unmodulated_mode_enable;
		logic            fsk;
		logic            end_of_cycle_irq_enable;
		logic            modulator_enable;
		logic            modulator_enable_d;
		logic            clear_armed;
		logic            irq_sts;
		logic            irq_msk;
		logic [2:0]      pre_cnt;
		logic [7:0]      car_cnt;
		logic            car_out;
		logic            car_sec;
		logic            active;
		logic            mark;
		logic [15:0]     mod_cnt;
		logic [15:0]     space_r;
		logic            pin_out;
		logic            pin_oe;
		logic            irq;
		logic [7:0]      rdata;
	} state_t;

	localparam state_t STATE_RESET = '0;

endpackage
